//--- verilog/file_move_or_regs.vh
// constants for the file-move / or-with-file execution block
`ifndef FILE_MOVE_OR_REGS_VH
`define FILE_MOVE_OR_REGS_VH
`define OPC_HI_MSB 13
`define OPC_HI_LSB 12
`define OPC_LO_MSB 11
`define OPC_LO_LSB 8
`define DEST_BIT 7
`define FADDR_MSB 6
`define FADDR_LSB 0
`define FLAG_RESET 1'h0
`define OPC_HI_BYTE_OPS 2'h0
`define OPC_COPY_FILE 4'h8
`define OPC_OR_ACC_FILE 4'h4
`define PHASE_DECODE 2'h0
`define PHASE_READ 2'h1
`define PHASE_PROCESS 2'h2
`define PHASE_WRITEBACK 2'h3
`define ACC_RESET 8'h00
`define DATA_ZERO 8'h00
`define ADDR_RESET 7'h00
`define INSTR_RESET 14'h0000
`endif

//--- verilog/file_move_or_exec.v
// execution of the copy-file and or-accumulator-with-file instructions
// What this block does
// RULE1: copy_file_instr opcode 1000, dest bit d, 7-bit file address; read file, deliver to d.
// RULE2: d=0 copy writes the read value into the accumulator; file untouched.
// RULE3: d=1 copy writes the value back into the same file register; accumulator untouched.
// RULE4: copy sets zero flag when moved value is zero, clears it otherwise.
// RULE5: four phases: decode, read file, process data, write destination.
// RULE6: or_acc_file_instr ORs accumulator with file; d picks destination; zero flag updated.
`include "file_move_or_regs.vh"
`default_nettype none
module file_move_or_exec #(
   parameter DATA_W = 8,
   parameter ADDR_W = 7
) (
   input wire clk_sys_i,
   input wire rst_n_i,
   input wire [13:0] instr_i,
   input wire instr_valid_i,
   input wire [DATA_W-1:0] file_rdata_i,
   output reg [ADDR_W-1:0] file_addr_o,
   output reg [DATA_W-1:0] file_wdata_o,
   output reg file_we_o,
   output reg [DATA_W-1:0] acc_o,
   output reg zero_o,
   output reg zero_we_o,
   output reg [1:0] phase_o,
   output wire busy_o
);
   localparam OP_NONE = 2'h0;
   localparam OP_COPY = 2'h1;
   localparam OP_OR = 2'h2;

   wire [1:0] opc_hi;
   wire [3:0] opc_lo;
   wire is_byte_op;
   wire is_copy;
   wire is_or;
   wire in_decode;
   wire in_read;
   wire in_process;
   wire in_writeback;
   wire result_zero;
   reg [1:0] op;
   reg dest;
   reg [DATA_W-1:0] operand;
   reg [DATA_W-1:0] result;
   reg [1:0] next_phase;
   reg [1:0] next_op;
   reg next_dest;
   reg [ADDR_W-1:0] next_file_addr;
   reg [DATA_W-1:0] next_operand;
   reg [DATA_W-1:0] next_result;
   reg [DATA_W-1:0] next_acc;
   reg next_zero;
   reg next_zero_we;
   reg [DATA_W-1:0] next_file_wdata;
   reg next_file_we;

   // opcode fields of the word on the instruction bus
   assign opc_hi = instr_i[`OPC_HI_MSB:`OPC_HI_LSB];
   assign opc_lo = instr_i[`OPC_LO_MSB:`OPC_LO_LSB];
   assign is_byte_op = (opc_hi == `OPC_HI_BYTE_OPS);
   assign is_copy = instr_valid_i && is_byte_op && (opc_lo == `OPC_COPY_FILE); // RULE1
   assign is_or = instr_valid_i && is_byte_op && (opc_lo == `OPC_OR_ACC_FILE); // RULE6
   assign in_decode = (phase_o == `PHASE_DECODE);
   assign in_read = (phase_o == `PHASE_READ);
   assign in_process = (phase_o == `PHASE_PROCESS);
   assign in_writeback = (phase_o == `PHASE_WRITEBACK);
   assign result_zero = (result == `DATA_ZERO); // RULE4 RULE6
   assign busy_o = (op != OP_NONE);

   // free-running phase sequence
   always @* begin
      case (phase_o)
         `PHASE_DECODE: next_phase = `PHASE_READ;
         `PHASE_READ: next_phase = `PHASE_PROCESS;
         `PHASE_PROCESS: next_phase = `PHASE_WRITEBACK;
         default: next_phase = `PHASE_DECODE;
      endcase
   end

   // decode: latch operation, destination and file address
   always @* begin
      next_op = op;
      next_dest = dest;
      next_file_addr = file_addr_o;
      if (in_decode) begin
         // RULE5
         next_dest = instr_i[`DEST_BIT];
         next_file_addr = instr_i[`FADDR_MSB:`FADDR_LSB]; // RULE1
         if (is_copy) begin
            next_op = OP_COPY; // RULE1
         end else if (is_or) begin
            next_op = OP_OR; // RULE6
         end else begin
            next_op = OP_NONE;
         end
      end else if (in_writeback) begin
         next_op = OP_NONE;
      end
   end

   // read the addressed file register
   always @* begin
      next_operand = operand;
      if (in_read) begin
         next_operand = file_rdata_i; // RULE5
      end
   end

   // process the data
   always @* begin
      next_result = result;
      if (in_process) begin
         if (op == OP_OR) begin
            next_result = operand | acc_o; // RULE6
         end else begin
            next_result = operand; // RULE1
         end
      end
   end

   // write the destination and the zero flag
   always @* begin
      next_acc = acc_o;
      next_zero = zero_o;
      next_zero_we = 1'h0;
      next_file_wdata = file_wdata_o;
      next_file_we = 1'h0;
      if (in_writeback && (op != OP_NONE)) begin
         // RULE5
         next_zero = result_zero; // RULE4 RULE6
         next_zero_we = 1'h1;
         if (dest) begin
            next_file_wdata = result; // RULE3 RULE6
            next_file_we = 1'h1;
         end else begin
            next_acc = result; // RULE2 RULE6
         end
      end
   end

   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         phase_o <= `PHASE_DECODE;
      end else begin
         phase_o <= next_phase; // RULE5
      end
   end

   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         op <= OP_NONE;
      end else begin
         op <= next_op;
      end
   end

   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         dest <= `FLAG_RESET;
      end else begin
         dest <= next_dest;
      end
   end

   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         file_addr_o <= `ADDR_RESET;
      end else begin
         file_addr_o <= next_file_addr;
      end
   end

   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         operand <= `DATA_ZERO;
      end else begin
         operand <= next_operand;
      end
   end

   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         result <= `DATA_ZERO;
      end else begin
         result <= next_result;
      end
   end

   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         acc_o <= `ACC_RESET;
      end else begin
         acc_o <= next_acc;
      end
   end

   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         zero_o <= `FLAG_RESET;
      end else begin
         zero_o <= next_zero;
      end
   end

   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         zero_we_o <= `FLAG_RESET;
      end else begin
         zero_we_o <= next_zero_we;
      end
   end

   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         file_wdata_o <= `DATA_ZERO;
      end else begin
         file_wdata_o <= next_file_wdata;
      end
   end

   always @(posedge clk_sys_i) begin
      if (!rst_n_i) begin
         file_we_o <= `FLAG_RESET;
      end else begin
         file_we_o <= next_file_we;
      end
   end
endmodule
`default_nettype wire

//--- verif/file_move_or_asserts.sv
// checker for the copy and or execution block
`default_nettype none
module file_move_or_asserts (
   input wire logic clk_sys_i,
   input wire logic rst_n_i,
   input wire logic instr_valid_i,
   input wire logic [13:0] instr_i,
   input wire logic [7:0] file_rdata_i,
   input wire logic [6:0] file_addr_o,
   input wire logic [7:0] file_wdata_o,
   input wire logic file_we_o,
   input wire logic [7:0] acc_o,
   input wire logic zero_o,
   input wire logic zero_we_o,
   input wire logic [1:0] phase_o,
   input wire logic busy_o
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!rst_n_i);
   wire [5:0] op = phase_o == 2'h0 && instr_valid_i ? instr_i[13:8] : 6'h00;
   wire cp = op == 6'h08;
   wire orr = op == 6'h04;
   wire dec = phase_o == 2'h0;
   sequence s_taken; cp || orr; endsequence
   sequence s_refused; dec && !cp && !orr; endsequence
   sequence s_copy_acc; cp && !instr_i[7]; endsequence
   sequence s_copy_self; cp && instr_i[7]; endsequence
   sequence s_or_acc; orr && !instr_i[7]; endsequence
   sequence s_or_self; orr && instr_i[7]; endsequence
   AST_ADDR: assert property (s_taken |=> file_addr_o == $past(instr_i[6:0]));
   AST_REFUSE: assert property (s_refused |-> ##4 !file_we_o && !zero_we_o);
   AST_ACC: assert property (s_copy_acc |-> ##4 acc_o == $past(file_rdata_i, 3) && !file_we_o);
   AST_SELF: assert property (s_copy_self |-> ##4 file_we_o && acc_o == $past(acc_o, 4)
      && file_wdata_o == $past(file_rdata_i, 3));
   AST_ZERO: assert property (cp |-> ##4 zero_we_o && zero_o == !$past(file_rdata_i, 3));
   AST_OR: assert property (s_or_acc |-> ##4 acc_o == ($past(acc_o, 4) | $past(file_rdata_i, 3)));
   AST_OR_SELF: assert property (s_or_self |-> ##4 file_we_o && acc_o == $past(acc_o, 4)
      && file_wdata_o == ($past(acc_o, 4) | $past(file_rdata_i, 3)));
   AST_OR_ZERO: assert property (orr |-> ##4 zero_we_o && zero_o == !($past(acc_o, 4) | $past(file_rdata_i, 3)));
   AST_PHASE: assert property (phase_o == 2'h3 |=> phase_o == 2'h0 ##1 phase_o == 2'h1);
   AST_STEP: assert property (phase_o != 2'h3 |=> phase_o == $past(phase_o) + 2'h1);
   AST_BUSY: assert property (s_taken |=> busy_o [*3] ##1 !busy_o);
endmodule
bind file_move_or_exec file_move_or_asserts i_chk (
   .clk_sys_i(clk_sys_i),
   .rst_n_i(rst_n_i),
   .instr_valid_i(instr_valid_i),
   .instr_i(instr_i),
   .file_rdata_i(file_rdata_i),
   .file_addr_o(file_addr_o),
   .file_wdata_o(file_wdata_o),
   .file_we_o(file_we_o),
   .acc_o(acc_o),
   .zero_o(zero_o),
   .zero_we_o(zero_we_o),
   .phase_o(phase_o),
   .busy_o(busy_o)
);
`default_nettype wire

//--- verif/tb_file_move_or_exec.sv
// testbench for the copy and or execution block
`default_nettype none
module tb_file_move_or_exec;
timeunit 1ns;
timeprecision 1ns;
logic clk_sys_i = 0, rst_n_i = 0, instr_valid_i = 0, file_we_o, zero_o, zero_we_o, busy_o;
logic [13:0] instr_i = 14'h0000;
logic [7:0] file_rdata_i = 8'h00, file_wdata_o, acc_o;
logic [6:0] file_addr_o;
logic [1:0] phase_o;
// rows: instruction, file data, then expected accumulator, zero flag, file write
logic [31:0] rows [6] = '{32'h20164644, 32'h20000002, 32'h2A156802, 32'h11FC4C4C, 32'h2300004F, 32'h1202444D};
int fails = 0, checked = 0;
file_move_or_exec i_file_move_or_exec (
   .clk_sys_i(clk_sys_i),
   .rst_n_i(rst_n_i),
   .instr_i(instr_i),
   .instr_valid_i(instr_valid_i),
   .file_rdata_i(file_rdata_i),
   .file_addr_o(file_addr_o),
   .file_wdata_o(file_wdata_o),
   .file_we_o(file_we_o),
   .acc_o(acc_o),
   .zero_o(zero_o),
   .zero_we_o(zero_we_o),
   .phase_o(phase_o),
   .busy_o(busy_o)
);
task automatic chk(string name, logic [9:0] e, logic [9:0] s);
   checked++;
   if (e !== s) begin
      fails++;
      $display("mismatch %s exp %h got %h", name, e, s);
   end
endtask
task final_report;
   if (fails == 0 && checked > 0) $display("ALL TESTS PASSED");
   else $display("TESTS FAILED");
   $finish;
endtask
initial forever #50 clk_sys_i = ~clk_sys_i;
initial begin
   repeat (3) @(negedge clk_sys_i);
   {rst_n_i, instr_valid_i} = 2'h3;
   foreach (rows[i]) begin
      {instr_i, file_rdata_i} = rows[i][31:10];
      repeat (4) @(negedge clk_sys_i);
      chk("outputs", rows[i][9:0], {acc_o, zero_o, file_we_o});
   end
   chk("file_wdata_o", 10'h093, {2'h0, file_wdata_o});
   chk("zero_we_o", 10'h001, {9'h000, zero_we_o});
   // valid low at decode: accumulator, zero flag and write strobes may not change
   {instr_valid_i, instr_i, file_rdata_i} = {1'h0, 14'h0805, 8'h55};
   repeat (4) @(negedge clk_sys_i);
   chk("refused", 10'h04C, {acc_o, zero_o, file_we_o});
   chk("zero_we_o", 10'h000, {9'h000, zero_we_o});
   // self copy; a new word during the read phase must be ignored
   {instr_valid_i, instr_i, file_rdata_i} = {1'h1, 14'h0885, 8'hA5};
   @(negedge clk_sys_i);
   chk("file_addr_o", 10'h005, {3'h0, file_addr_o});
   chk("busy_o", 10'h001, {9'h000, busy_o});
   instr_i = 14'h0405;
   repeat (3) @(negedge clk_sys_i);
   chk("self_copy", 10'h04D, {acc_o, zero_o, file_we_o});
   chk("file_wdata_o", 10'h0A5, {2'h0, file_wdata_o});
   chk("busy_o", 10'h000, {9'h000, busy_o});
   instr_valid_i = 0;
   @(negedge clk_sys_i);
   rst_n_i = 0;
   @(negedge clk_sys_i);
   chk("reset", 10'h000, {acc_o, phase_o});
   final_report;
end
endmodule
`default_nettype wire
